//--- bench/jtag_link_properties.sv
// Timing checks on the four-wire link between the master and the controller.
// Assumes it is instantiated beside the link interface, on the master's system clock.
`timescale 1ns/10ps
module jtag_link_properties (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_oe,
  input wire logic tdi,
  input wire logic tdi_oe,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // All link checks share the system clock and its reset
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Outputs launch after the falling edge, never while TCK is high
  a_tdo_launch_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
    else $error("tdo moved while tck was high");
  a_tdo_oe_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck was high");
  // The master changes TMS and TDI away from the sampling edge
  a_tms_change_low: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck was high");
  a_tdi_change_low: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck was high");
  // Seven cycles each phase keeps TCK below 10 MHz
  a_tck_high_time: assert property ($rose(tck) |=> tck [*6] ##1 !tck)
    else $error("tck high phase not seven cycles");
  a_tck_low_time: assert property ($fell(tck) |=> !tck [*6])
    else $error("tck low phase too short");
  // TDO is released right after reset
  a_tdo_off_reset: assert property (!$past(reset_n_i) |-> !tdo_oe)
    else $error("tdo driven after reset");
  // TCK stands still whenever no command owns the link
  a_tck_idle_low: assert property (!tms_oe |-> !tck)
    else $error("tck running outside a command");
  // TDO is only driven while a scan is in progress
  a_tdo_in_scan: assert property (tdo_oe |-> tms_oe)
    else $error("tdo driven outside a scan");

  cover property ($rose(tdo_oe));
  cover property (tms && $rose(tck));
  cover property ($fell(tdo_oe) ##[1:40] $fell(tms_oe));
endmodule

//--- bench/jtag_tap_controller_tb.sv
// Self-checking bench: master and controller joined through the link interface.
// Assumes the master sequences complete scans and the controller starts from power-up reset.
`timescale 1ns/10ps
module jtag_tap_controller_tb;
  import jtag_pkg::*;
  localparam logic [3:0] T_REV = 4'h3; // Arbitrary value
  localparam logic [15:0] T_PART = 16'h1234; // Arbitrary value
  localparam logic [10:0] T_MFR = 11'h155; // Arbitrary value
  localparam logic [31:0] ID_EXP = {T_REV, T_PART, T_MFR, 1'b1};
  localparam logic [BSR_LEN-1:0] PINS = {49{8'h3C}};
  localparam logic [BSR_LEN-1:0] LOAD = {49{8'h96}};
  localparam logic [3:0] CODES [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'hF, 4'h8};

  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic en_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_kind_i = 2'h0;
  logic [LEN_W-1:0] cmd_len_i = '0;
  logic [BSR_LEN-1:0] cmd_data_i = '0;
  logic [BSR_LEN-1:0] pins_i = PINS;
  logic cmd_ready_o;
  logic done_o;
  logic refused_o;
  logic [BSR_LEN-1:0] res_data_o;
  logic [BSR_LEN-1:0] bsr_out_o;
  logic bsr_drive_o;
  logic highz_o;
  logic self_test_run_o;
  logic [IR_W-1:0] instr_o;
  logic got_ref;
  logic got_rdy;
  int err_total = 0;
  int tests_run = 0;

  jtag_link_if i_jtag_link_if ();

  jtag_master i_jtag_master (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(en_i),
    .link(i_jtag_link_if), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_kind_i(cmd_kind_i), .cmd_len_i(cmd_len_i), .cmd_data_i(cmd_data_i),
    .done_o(done_o), .refused_o(refused_o), .res_data_o(res_data_o));

  jtag_tap #(.ID_REV(T_REV), .ID_PART(T_PART), .ID_MFR(T_MFR)) i_jtag_tap (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(en_i), .link(i_jtag_link_if),
    .pins_i(pins_i), .bsr_out_o(bsr_out_o), .bsr_drive_o(bsr_drive_o),
    .highz_o(highz_o), .self_test_run_o(self_test_run_o), .instr_o(instr_o));

  jtag_link_properties i_jtag_link_properties (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .tck(i_jtag_link_if.tck), .tms(i_jtag_link_if.tms), .tms_oe(i_jtag_link_if.tms_oe),
    .tdi(i_jtag_link_if.tdi), .tdi_oe(i_jtag_link_if.tdi_oe),
    .tdo(i_jtag_link_if.tdo), .tdo_oe(i_jtag_link_if.tdo_oe));

  // 125 MHz system clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check_vec(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One command through the master; waits for done or refusal under a bound
  task automatic do_cmd(input logic [1:0] kind, input int len, input logic [BSR_LEN-1:0] data);
    int n;
    @(posedge mclk_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_kind_i = kind;
    cmd_len_i = LEN_W'(len);
    cmd_data_i = data;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 50);
    #1;
    cmd_valid_i = 1'b0;
    // Ready just after the taking edge: low for a started command, high after a refusal
    got_rdy = cmd_ready_o;
    // Longest scan is about 5600 cycles, so this bound only trips on a hang
    while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 8000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    got_ref = refused_o;
    if (n >= 8000) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      report_and_stop();
    end
  endtask

  task automatic t_power_up();
    check_vec(BSR_LEN'({instr_o, i_jtag_link_if.tdo_oe, cmd_ready_o}),
      BSR_LEN'({INS_IDCODE, 1'b0, 1'b1}));
  endtask

  // Forty bits out of the ID path: the word, then the first bits shifted in
  task automatic t_idcode();
    do_cmd(CMD_RESET, 0, '0);
    check_vec(BSR_LEN'(instr_o), BSR_LEN'(INS_IDCODE));
    do_cmd(CMD_DR, 40, BSR_LEN'(8'hA5));
    check_vec(res_data_o, BSR_LEN'({8'hA5, ID_EXP}));
    check_vec(BSR_LEN'({got_rdy, cmd_ready_o}), BSR_LEN'(2'h1));
  endtask

  // Seven of the nine implemented codes (all but 2 and 3), their decode, and the one-bit bypass path through a two-bit scan where one applies
  task automatic t_decode();
    logic [3:0] c;
    for (int i = 0; i < 7; i++) begin
      c = CODES[i];
      do_cmd(CMD_IR, 4, BSR_LEN'(c));
      check_vec(res_data_o, BSR_LEN'(IR_CAPTURE));
      check_vec(BSR_LEN'({instr_o, bsr_drive_o, highz_o, self_test_run_o}),
        BSR_LEN'({c, c == 4'h0 || c == 4'h5, c == 4'h6, c == 4'h8}));
      if (c inside {4'h5, 4'h6, 4'hF, 4'h8}) begin
        do_cmd(CMD_DR, 2, BSR_LEN'(2'h3));
        check_vec(res_data_o, BSR_LEN'(2'h2));
      end
    end
  endtask

  // Reserved code and illegal kind are turned away, instruction kept
  task automatic t_refuse();
    do_cmd(CMD_IR, 4, BSR_LEN'(4'h4));
    check_vec(BSR_LEN'({got_ref, got_rdy, instr_o}), BSR_LEN'({2'h3, INS_SELF_TEST}));
    do_cmd(2'h3, 4, '0);
    check_vec(BSR_LEN'(got_ref), BSR_LEN'(1'b1));
  endtask

  // Full boundary scans: capture pins, preload, survive a TAP reset, then external test
  task automatic t_boundary();
    do_cmd(CMD_IR, 4, BSR_LEN'(INS_SAMPLE));
    do_cmd(CMD_DR, BSR_LEN, LOAD);
    check_vec(res_data_o, PINS);
    check_vec(bsr_out_o, LOAD);
    do_cmd(CMD_RESET, 0, '0);
    check_vec(bsr_out_o, LOAD);
    check_vec(BSR_LEN'(instr_o), BSR_LEN'(INS_IDCODE));
    pins_i = ~PINS;
    do_cmd(CMD_IR, 4, BSR_LEN'(INS_EXTEST));
    do_cmd(CMD_DR, BSR_LEN, '0);
    check_vec(res_data_o, ~PINS);
    check_vec(BSR_LEN'({bsr_out_o, bsr_drive_o}), BSR_LEN'(1'b1));
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    t_power_up();
    t_idcode();
    t_decode();
    t_refuse();
    t_boundary();
    report_and_stop();
  end
endmodule

//--- src/jtag_link_if.sv
// Four-wire test port link between the master and the controller.
// Assumes the master and the controller resolve pulled-up pins from the enables carried here.
`timescale 1ns/10ps
interface jtag_link_if;
  logic tck;
  logic tms;
  logic tms_oe;
  logic tdi;
  logic tdi_oe;
  logic tdo;
  logic tdo_oe;

  modport master (
    output tck,
    output tms,
    output tms_oe,
    output tdi,
    output tdi_oe,
    input tdo,
    input tdo_oe
  );

  modport device (
    input tck,
    input tms,
    input tms_oe,
    input tdi,
    input tdi_oe,
    output tdo,
    output tdo_oe
  );
endinterface

//--- src/jtag_master.sv
// Test port master: makes TCK by division and walks the controller.
// Assumes one device on the chain; the controller is in idle when an IR or DR command starts.
`timescale 1ns/10ps
module jtag_master
  import jtag_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  jtag_link_if.master link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_kind_i,
  input wire logic [LEN_W-1:0] cmd_len_i,
  input wire logic [BSR_LEN-1:0] cmd_data_i,
  output logic done_o,
  output logic refused_o,
  output logic [BSR_LEN-1:0] res_data_o
);

  mst_state_t st_q;
  logic [LEN_W-1:0] cnt_q;
  logic [3:0] div_q;
  logic tck_q;
  logic [1:0] kind_q;
  logic [LEN_W-1:0] len_q;
  logic [BSR_LEN-1:0] data_q;
  logic [BSR_LEN-1:0] res_q;
  logic done_q;
  logic refused_q;
  logic tdo_s1_q;
  logic tdo_s2_q;

  // Command check: reserved codes never reach the device through a four-bit IR scan
  wire accept = en_i & cmd_valid_i & cmd_ready_o;
  wire ir_bad = (cmd_kind_i == CMD_IR) & ~INS_LEGAL_MASK[cmd_data_i[IR_W-1:0]]; // RL13
  wire len_bad = (cmd_kind_i != CMD_RESET) & ((cmd_len_i == '0) | (cmd_len_i > BSR_LEN_V));
  wire cmd_bad = (cmd_kind_i == 2'h3) | ir_bad | len_bad;

  // Bit sequencing
  wire busy = (st_q != M_IDLE);
  wire tick = busy & (div_q == TCK_HALF_LAST);
  wire rise_ev = tick & ~tck_q;
  wire fall_ev = tick & tck_q;
  wire [5:0] head_pat = (kind_q == CMD_RESET) ? HEAD_RESET :
                        (kind_q == CMD_IR) ? HEAD_IR : HEAD_DR;
  wire [LEN_W-1:0] head_len = (kind_q == CMD_RESET) ? HEAD_RESET_LEN :
                              (kind_q == CMD_IR) ? HEAD_IR_LEN : HEAD_DR_LEN;
  wire head_last = (cnt_q == head_len - 9'h001);
  wire shift_last = (cnt_q == len_q - 9'h001);
  wire tail_last = (cnt_q == TAIL_LEN - 9'h001);
  wire tms_bit = (st_q == M_HEAD) ? head_pat[cnt_q[2:0]] : // RL5 RL23
                 (st_q == M_SHIFT) ? shift_last :
                 (st_q == M_TAIL) ? TAIL_PAT[cnt_q[0]] : 1'b0;
  // Released lines float to the pulled-up level between commands
  wire tdo_level = link.tdo_oe ? link.tdo : 1'b1;

  assign cmd_ready_o = ~busy;
  assign link.tck = tck_q;
  assign link.tms = tms_bit;
  assign link.tms_oe = busy;
  assign link.tdi = data_q[0];
  assign link.tdi_oe = (st_q == M_SHIFT);
  assign done_o = done_q;
  assign refused_o = refused_q;
  assign res_data_o = res_q;

  // TDO comes from another clock's logic
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else if (en_i) begin
      tdo_s1_q <= tdo_level;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  // Divider; TCK idles low and never runs above the 10 MHz limit
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q <= 4'h0;
      tck_q <= 1'b0;
    end else if (en_i) begin
      if (!busy) begin
        div_q <= 4'h0;
        tck_q <= 1'b0;
      end else if (tick) begin
        div_q <= 4'h0;
        tck_q <= ~tck_q; // RL18
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // Sequencer advances on each falling TCK so TMS is set a half period early
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= M_IDLE;
      cnt_q <= '0;
      kind_q <= CMD_RESET;
      len_q <= '0;
    end else if (en_i) begin
      unique case (st_q)
        M_IDLE: begin
          if (accept && !cmd_bad) begin
            st_q <= M_HEAD;
            cnt_q <= '0;
            kind_q <= cmd_kind_i;
            len_q <= cmd_len_i;
          end
        end
        M_HEAD: begin
          if (fall_ev) begin
            cnt_q <= head_last ? '0 : cnt_q + 9'h001;
            if (head_last) begin
              st_q <= (kind_q == CMD_RESET) ? M_IDLE : M_SHIFT;
            end
          end
        end
        M_SHIFT: begin
          if (fall_ev) begin
            cnt_q <= shift_last ? '0 : cnt_q + 9'h001;
            if (shift_last) begin
              st_q <= M_TAIL; // RL14
            end
          end
        end
        M_TAIL: begin
          if (fall_ev) begin
            cnt_q <= tail_last ? '0 : cnt_q + 9'h001;
            if (tail_last) begin
              st_q <= M_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Outgoing data shifts at the fall, returning data is taken at the rise
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= '0;
      res_q <= '0;
    end else if (en_i) begin
      if (accept && !cmd_bad) begin
        data_q <= cmd_data_i;
        res_q <= '0;
      end else if (st_q == M_SHIFT) begin
        if (rise_ev) begin
          res_q[cnt_q] <= tdo_s2_q;
        end
        if (fall_ev) begin
          data_q <= data_q >> 1;
        end
      end
    end
  end

  // One-cycle completion and refusal strobes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (en_i) begin
      done_q <= fall_ev & ((st_q == M_TAIL) & tail_last |
                           (st_q == M_HEAD) & head_last & (kind_q == CMD_RESET));
      refused_q <= accept & cmd_bad;
    end
  end

endmodule

//--- src/jtag_pkg.sv
// Shared constants for the test access port controller and its master.
// Assumes both ends run on one 125 MHz system clock with their own resets.
package jtag_pkg;

  // Scan register sizes
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 392;
  localparam int LEN_W = 9;

  // Instruction codes
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_RESULT_SCAN = 4'h2;
  localparam logic [3:0] INS_CTRL_SCAN = 4'h3;
  localparam logic [3:0] INS_CLAMP = 4'h5;
  localparam logic [3:0] INS_HIGHZ = 4'h6;
  localparam logic [3:0] INS_IDCODE = 4'h7;
  localparam logic [3:0] INS_SELF_TEST = 4'h8;
  localparam logic [3:0] INS_BYPASS = 4'hF;
  // One bit per implemented code; the other seven are reserved
  localparam logic [15:0] INS_LEGAL_MASK = 16'h81EF;
  // Pattern loaded into the instruction shifter in Capture-IR
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identification word layout
  localparam int ID_REV_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_MARKER = 1'h1;

  // Test clock timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCK_MAX_MHZ = 10;
  localparam int TCK_MIN_PERIOD_NS = 1000 / TCK_MAX_MHZ;
  localparam int TCK_HALF_CYC = (TCK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TCK_HALF_LAST = 4'(TCK_HALF_CYC - 1);

  // Master command kinds
  localparam logic [1:0] CMD_RESET = 2'h0;
  localparam logic [1:0] CMD_IR = 2'h1;
  localparam logic [1:0] CMD_DR = 2'h2;

  // TMS sequences, sent LSB first
  localparam int RESET_HIGH_EDGES = 5;
  localparam logic [5:0] HEAD_RESET = 6'h1F;
  localparam logic [LEN_W-1:0] HEAD_RESET_LEN = 9'h006;
  localparam logic [5:0] HEAD_IR = 6'h03;
  localparam logic [LEN_W-1:0] HEAD_IR_LEN = 9'h004;
  localparam logic [5:0] HEAD_DR = 6'h01;
  localparam logic [LEN_W-1:0] HEAD_DR_LEN = 9'h003;
  localparam logic [1:0] TAIL_PAT = 2'h1;
  localparam logic [LEN_W-1:0] TAIL_LEN = 9'h002;
  localparam logic [LEN_W-1:0] BSR_LEN_V = 9'(BSR_LEN);

  // Controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UP_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UP_IR = 16'h8000
  } tap_state_t;

  // Master sequencer states, one-hot
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_HEAD = 4'h2,
    M_SHIFT = 4'h4,
    M_TAIL = 4'h8
  } mst_state_t;

endpackage

//--- src/jtag_tap.sv
// Test access port controller: state machine, instruction register,
// bypass, identification and boundary scan registers.
// Assumes TCK, TMS and TDI arrive asynchronously and TCK is far slower
// than mclk_i; TCK edges are found by oversampling.
`timescale 1ns/10ps
// Functional notes
// [RL1] Sample on TCK rise, drive on fall
// [RL2] Undriven TMS reads high
// [RL3] TDI enters selected register MSB
// [RL4] TDO is LSB, enabled only while shifting
// [RL5] Five TMS-high edges reset, memory unaffected
// [RL6] Reset starts controller with TDO released
// [RL7] Instruction selects exactly one data register
// [RL8] Four-bit IR, IDCODE after any reset
// [RL9] Capture-IR loads 01 into low bits
// [RL10] One-bit bypass cleared on capture
// [RL11] Boundary register captures pins, then shifts
// [RL12] IDCODE loads fixed 32-bit word
// [RL13] Reserved codes unused; no internal test
// [RL14] New instruction applies at Update-IR
// [RL15] All-zero code drives boundary onto pins
// [RL16] High-Z code bypasses and floats outputs
// [RL17] Sample/preload snapshots pins, updates later
// [RL18] Master keeps TCK at 10 MHz maximum
// [RL19] Self-test run via port, own clock
// [RL20] Codes 0000 extest, 1111 bypass, 0111 id
// [RL21] Codes 0110 highz, 0101 clamp, 0001 sample
// [RL22] ID word: revision, part, maker, one
// [RL23] Standard sixteen-state TMS-driven state machine
module jtag_tap
  import jtag_pkg::*;
#(
  parameter logic [3:0] ID_REV = 4'h2, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h5A5A, // Arbitrary value
  parameter logic [10:0] ID_MFR = 11'h0A5 // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  jtag_link_if.device link,
  input wire logic [BSR_LEN-1:0] pins_i,
  output logic [BSR_LEN-1:0] bsr_out_o,
  output logic bsr_drive_o,
  output logic highz_o,
  output logic self_test_run_o,
  output logic [IR_W-1:0] instr_o
);

  tap_state_t state_q;
  tap_state_t state_d;
  logic tck_s1_q;
  logic tck_s2_q;
  logic tck_s3_q;
  logic tms_s1_q;
  logic tms_s2_q;
  logic tdi_s1_q;
  logic tdi_s2_q;
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  logic byp_q;
  logic [ID_W-1:0] id_sh_q;
  logic [BSR_LEN-1:0] bsr_sh_q;
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic tdo_q;
  logic tdo_oe_q;

  // Pull-ups on TMS and TDI: a released line reads high
  wire tms_level = link.tms_oe ? link.tms : 1'b1; // RL2
  wire tdi_level = link.tdi_oe ? link.tdi : 1'b1;

  // Three samples of TCK: the first two only synchronise, edges use the later pair
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b1;
      tdi_s2_q <= 1'b1;
    end else if (en_i) begin
      tck_s1_q <= link.tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms_level;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi_level;
      tdi_s2_q <= tdi_s1_q;
    end
  end

  // TMS and TDI ride the same synchroniser depth as TCK, so they line up with the edge
  wire tck_rise = en_i & tck_s2_q & ~tck_s3_q; // RL1
  wire tck_fall = en_i & ~tck_s2_q & tck_s3_q; // RL1
  wire tms = tms_s2_q;
  wire tdi = tdi_s2_q;

  // State decode
  wire in_reset = (state_q == TAP_RESET);
  wire in_cap_ir = (state_q == TAP_CAP_IR);
  wire in_sh_ir = (state_q == TAP_SH_IR);
  wire in_up_ir = (state_q == TAP_UP_IR);
  wire in_cap_dr = (state_q == TAP_CAP_DR);
  wire in_sh_dr = (state_q == TAP_SH_DR);
  wire in_up_dr = (state_q == TAP_UP_DR);

  // Instruction decode; reserved and self-test codes fall back to bypass
  wire is_extest = (ir_q == INS_EXTEST); // RL20
  wire is_sample = (ir_q == INS_SAMPLE); // RL21
  wire is_clamp = (ir_q == INS_CLAMP); // RL21
  wire is_highz = (ir_q == INS_HIGHZ); // RL21
  wire is_self_test = (ir_q == INS_SELF_TEST);
  wire sel_id = (ir_q == INS_IDCODE); // RL20
  wire sel_bsr = is_extest | is_sample; // RL7
  wire sel_byp = ~sel_id & ~sel_bsr; // RL7 RL13 RL16

  // Identification word, fixed in logic
  wire [ID_W-1:0] id_word = {ID_REV, ID_PART, ID_MFR, ID_MARKER}; // RL22

  // Bit presented to TDO: the LSB of whichever path is selected
  wire dr_lsb = sel_id ? id_sh_q[0] : (sel_bsr ? bsr_sh_q[0] : byp_q);
  wire tdo_bit = in_sh_ir ? ir_sh_q[0] : dr_lsb; // RL4

  // Pin-facing controls
  assign bsr_out_o = bsr_upd_q;
  assign bsr_drive_o = is_extest | is_clamp; // RL15
  assign highz_o = is_highz; // RL16
  // The memory swaps to the self-test clock while this is high
  assign self_test_run_o = is_self_test & (state_q == TAP_IDLE); // RL19
  assign instr_o = ir_q;
  assign link.tdo = tdo_q;
  assign link.tdo_oe = tdo_oe_q;

  // Next state from the sampled TMS
  always_comb begin
    unique case (state_q)
      TAP_RESET: state_d = tms ? TAP_RESET : TAP_IDLE; // RL23
      TAP_IDLE: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_d = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR: state_d = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: state_d = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_d = tms ? TAP_RESET : TAP_CAP_IR; // RL5
      TAP_CAP_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_d = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR: state_d = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: state_d = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      default: state_d = TAP_RESET;
    endcase
  end

  // State register; system reset stands in for the power-up reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= TAP_RESET; // RL6
    end else if (tck_rise) begin
      state_q <= state_d; // RL23
    end
  end

  // Instruction shifter: capture pattern, then shift from the MSB end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise) begin
      if (in_cap_ir) begin
        ir_sh_q <= IR_CAPTURE; // RL9
      end else if (in_sh_ir) begin
        ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]}; // RL3
      end
    end
  end

  // Active instruction changes only in Update-IR, or returns to IDCODE in reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ir_q <= INS_IDCODE; // RL8
    end else if (tck_fall) begin
      if (in_reset) begin
        ir_q <= INS_IDCODE; // RL8
      end else if (in_up_ir) begin
        ir_q <= ir_sh_q; // RL14
      end
    end
  end

  // Bypass and identification paths
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byp_q <= 1'b0;
      id_sh_q <= '0;
    end else if (tck_rise) begin
      if (in_cap_dr && sel_byp) begin
        byp_q <= 1'b0; // RL10
      end else if (in_sh_dr && sel_byp) begin
        byp_q <= tdi; // RL10
      end
      if (in_cap_dr && sel_id) begin
        id_sh_q <= id_word; // RL12
      end else if (in_sh_dr && sel_id) begin
        id_sh_q <= {tdi, id_sh_q[ID_W-1:1]}; // RL3 RL12
      end
    end
  end

  // Boundary shifter; a capture may catch a pin mid-transition, callers hold pins steady
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bsr_sh_q <= '0;
    end else if (tck_rise && sel_bsr) begin
      if (in_cap_dr) begin
        bsr_sh_q <= pins_i; // RL11 RL17
      end else if (in_sh_dr) begin
        bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]}; // RL3 RL11
      end
    end
  end

  // Boundary update stage holds the preload; TAP reset leaves it, so memory traffic is untouched
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bsr_upd_q <= '0;
    end else if (tck_fall && in_up_dr && sel_bsr) begin
      bsr_upd_q <= bsr_sh_q; // RL17 RL5
    end
  end

  // TDO launched on the fall and enabled only in the shift states
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0; // RL6
    end else if (tck_fall) begin
      tdo_q <= tdo_bit; // RL1 RL4
      tdo_oe_q <= in_sh_ir | in_sh_dr; // RL4
    end
  end

endmodule
